// ==== design/nvm_ctl_pkg.sv ====
// constants and types shared by the self-write controller
// assumes a single clock domain at 25 MHz
package nvm_ctl_pkg;
  localparam int unsigned clock_mhz = 25;
  localparam int unsigned word_width = 14;
  localparam int unsigned row_words = 32;
  localparam int unsigned row_bits = 5;
  localparam int unsigned addr_width = 15;
  localparam int unsigned flash_words = 16384;
  localparam int unsigned eeprom_words = 256;
  localparam logic [7:0] key_first = 8'h55;
  localparam logic [7:0] key_second = 8'hAA;
  localparam logic [4:0] last_latch = 5'h1F;
  localparam logic [13:0] erased_word = 14'h3FFF;
  localparam logic [7:0] erased_byte = 8'hFF;
  localparam int unsigned write_time_us = 2;
  localparam int unsigned write_cycles = write_time_us * clock_mhz;
  localparam logic [7:0] write_cycles_count = 8'(write_cycles);
  localparam logic [7:0] count_reset = 8'h00;
  typedef enum {st_idle, st_erase, st_program, st_ee_write} seq_state_type;
  typedef enum {key_none, key_got_first, key_armed} key_state_type;
endpackage : nvm_ctl_pkg

// ==== design/nvm_self_write_control.sv ====
// self-read of program flash and data eeprom, row erase and row programming of program flash, byte write of data eeprom
// assumes register strobes are one-cycle pulses from core logic on clock_i
`timescale 1ns/1ps
`default_nettype none
module nvm_self_write_control
  import nvm_ctl_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // register writes from the core
  input wire logic address_low_byte_we_i,
  input wire logic address_high_byte_we_i,
  input wire logic data_low_byte_we_i,
  input wire logic data_high_byte_we_i,
  input wire logic unlock_key_register_we_i,
  input wire logic [7:0] write_data_i,
  // memory_control_register bits
  input wire logic region_select_i,
  input wire logic latch_load_only_i,
  input wire logic erase_select_i,
  input wire logic write_enable_gate_i,
  input wire logic write_start_set_i,
  input wire logic read_start_set_i,
  input wire logic write_error_clear_i,
  // configuration
  input wire logic [1:0] write_protect_range_i,
  input wire logic program_code_protect_i,
  input wire logic data_code_protect_i,
  // external programmer
  input wire logic prog_read_i,
  input wire logic prog_bulk_erase_i,
  input wire logic [addr_width-1:0] prog_address_i,
  // fetch and indirect read port
  input wire logic [addr_width-1:0] fetch_address_i,
  // status
  output logic [addr_width-1:0] address_o,
  output logic [13:0] read_data_o,
  output logic write_busy_o,
  output logic read_busy_o,
  output logic write_error_flag_o,
  output logic [13:0] fetch_data_o,
  output logic [13:0] prog_data_o,
  output logic protect_cleared_o
);
  logic [13:0] flash [flash_words];
  logic [7:0] eeprom [eeprom_words];
  logic [13:0] latches [row_words];
  logic [7:0] data_low;
  logic [7:0] next_data_low;
  logic [addr_width-1:0] next_address;
  logic [13:0] next_read_data;
  key_state_type key_state, next_key_state;
  seq_state_type seq_state, next_seq_state;
  logic next_error;
  logic timer_start;
  logic timer_done;
  logic start_ok;
  logic protected_hit;
  logic bulk_done;

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  function automatic logic in_protected(input logic [1:0] range, input logic [13:0] a);
    case (range)
      2'b11: in_protected = 1'b0;
      2'b10: in_protected = (a < 14'h0200);
      2'b01: in_protected = (a < 14'h2000);
      default: in_protected = 1'b1;
    endcase
  endfunction : in_protected

  assign protected_hit = !region_select_i && in_protected(write_protect_range_i, address_o[13:0]);

  nvm_write_timer timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(timer_start),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------
  // unlock keys and register state
  // ----------------------------------------------------------------
  assign start_ok = write_start_set_i && write_enable_gate_i && key_state == key_armed;

  always_comb begin
    next_key_state = key_state;
    if (unlock_key_register_we_i) begin
      if (write_data_i == key_first) begin
        next_key_state = key_got_first;
      end else if (write_data_i == key_second && key_state == key_got_first) begin
        next_key_state = key_armed;
      end else begin
        next_key_state = key_none;
      end
    end else if (write_start_set_i || address_low_byte_we_i || data_low_byte_we_i) begin
      next_key_state = key_none;
    end
  end

  always_comb begin
    next_address = address_o;
    next_data_low = data_low;
    next_read_data = read_data_o;
    if (address_low_byte_we_i) begin
      next_address[7:0] = write_data_i;
    end
    if (address_high_byte_we_i) begin
      next_address[addr_width-1:8] = write_data_i[6:0];
    end
    if (data_low_byte_we_i) begin
      next_data_low = write_data_i;
      next_read_data[7:0] = write_data_i;
    end
    if (data_high_byte_we_i) begin
      next_read_data[13:8] = write_data_i[5:0];
    end
    if (read_start_set_i && seq_state == st_idle) begin
      if (region_select_i) begin
        next_read_data = {6'h00, eeprom[address_o[7:0]]};
      end else begin
        next_read_data = flash[address_o[13:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_seq_state = seq_state;
    next_error = write_error_flag_o;
    timer_start = 1'b0;
    if (write_error_clear_i) begin
      next_error = 1'b0;
    end
    case (seq_state)
      st_idle: begin
        if (write_start_set_i && write_enable_gate_i && key_state != key_armed) begin
          next_error = 1'b1;
        end else if (start_ok && protected_hit) begin
          next_error = 1'b1;
        end else if (start_ok && region_select_i) begin
          next_seq_state = st_ee_write;
          timer_start = 1'b1;
        end else if (start_ok && erase_select_i) begin
          next_seq_state = st_erase;
          timer_start = 1'b1;
        end else if (start_ok && !latch_load_only_i) begin
          next_seq_state = st_program;
          timer_start = 1'b1;
        end
      end
      st_erase, st_program, st_ee_write: begin
        if (timer_done) begin
          next_seq_state = st_idle;
        end
      end
      default: next_seq_state = st_idle;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      key_state <= key_none;
      seq_state <= st_idle;
      address_o <= '0;
      data_low <= 8'h00;
      read_data_o <= 14'h0000;
      write_error_flag_o <= (seq_state != st_idle);
    end else begin
      key_state <= next_key_state;
      seq_state <= next_seq_state;
      address_o <= next_address;
      data_low <= next_data_low;
      read_data_o <= next_read_data;
      write_error_flag_o <= next_error;
    end
  end

  // ----------------------------------------------------------------
  // arrays: latches, flash, eeprom
  // ----------------------------------------------------------------
  logic [13:0] staged;
  assign staged = {read_data_o[13:8], data_low};

  always_ff @(posedge clock_i) begin
    if (start_ok && !protected_hit && !region_select_i && !erase_select_i) begin
      latches[address_o[row_bits-1:0]] <= staged;
    end
    if (seq_state == st_erase && timer_done) begin
      for (int i = 0; i < row_words; i++) begin
        flash[{address_o[13:row_bits], 5'(i)}] <= erased_word;
      end
    end
    if (seq_state == st_program && timer_done) begin
      for (int i = 0; i < row_words; i++) begin
        flash[{address_o[13:row_bits], 5'(i)}] <= flash[{address_o[13:row_bits], 5'(i)}] & latches[i];
      end
    end
    if (seq_state == st_ee_write && timer_done) begin
      eeprom[address_o[7:0]] <= data_low;
    end
    if (prog_bulk_erase_i) begin
      for (int i = 0; i < flash_words; i++) begin
        flash[i] <= erased_word;
      end
      for (int i = 0; i < eeprom_words; i++) begin
        eeprom[i] <= erased_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // read paths and protection status
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fetch_data_o <= 14'h0000;
      prog_data_o <= 14'h0000;
      bulk_done <= 1'b0;
    end else begin
      fetch_data_o <= flash[fetch_address_i[13:0]];
      if (prog_read_i) begin
        prog_data_o <= program_code_protect_i ? 14'h0000 : flash[prog_address_i[13:0]];
      end
      if (prog_bulk_erase_i) begin
        bulk_done <= 1'b1;
      end
    end
  end

  assign protect_cleared_o = bulk_done;
  assign write_busy_o = (seq_state != st_idle);
  assign read_busy_o = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_needs_keys: assert property (@(posedge clock_i) disable iff (reset_i)
    (write_start_set_i && key_state != key_armed && seq_state == st_idle) |=> !write_busy_o)
    else $error("start taken without unlock");
  a_bad_start_error: assert property (@(posedge clock_i) disable iff (reset_i)
    (write_start_set_i && write_enable_gate_i && key_state != key_armed && seq_state == st_idle
     && !write_error_clear_i) |=> write_error_flag_o)
    else $error("broken unlock did not flag error");
  a_protect_refuse: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_ok && protected_hit && seq_state == st_idle) |=> !write_busy_o)
    else $error("protected start accepted");
  a_busy_ends: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(write_busy_o) |-> ##[1:60] !write_busy_o)
    else $error("write never finished");
  a_busy_length: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(write_busy_o) |-> write_busy_o [*8])
    else $error("write too short");
  a_latch_only_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_ok && latch_load_only_i && !erase_select_i && !region_select_i && seq_state == st_idle)
    |=> !write_busy_o)
    else $error("latch load started a write");
  a_commit_starts: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_ok && !latch_load_only_i && !protected_hit && seq_state == st_idle) |=> write_busy_o)
    else $error("commit not started");
  a_keys_order: assert property (@(posedge clock_i) disable iff (reset_i)
    (key_state == key_armed) |-> $past(key_state) != key_none)
    else $error("armed without first key");
  a_error_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
    (write_error_flag_o && !write_error_clear_i) |=> write_error_flag_o)
    else $error("error flag dropped without clear");
  a_region_bypass: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_ok && region_select_i && seq_state == st_idle) |=> seq_state == st_ee_write)
    else $error("eeprom write not started");
  c_ee_write: cover property (@(posedge clock_i) seq_state == st_ee_write);
  c_row_program: cover property (@(posedge clock_i) seq_state == st_program);
  c_row_erase: cover property (@(posedge clock_i) seq_state == st_erase);
  c_error: cover property (@(posedge clock_i) $rose(write_error_flag_o));
endmodule : nvm_self_write_control
`default_nettype wire

// ==== design/nvm_write_timer.sv ====
// one-shot timer that sets the length of a program or erase operation
// assumes start_i is a single-cycle pulse from the sequencer
`timescale 1ns/1ps
`default_nettype none
module nvm_write_timer
  import nvm_ctl_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // control
  input wire logic start_i,
  output logic done_o
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_done;
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start_i) begin
      next_count = write_cycles_count;
    end else if (count != count_reset) begin
      next_count = count - 8'h01;
      next_done = (count == 8'h01);
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count <= count_reset;
      done_o <= 1'b0;
    end else begin
      count <= next_count;
      done_o <= next_done;
    end
  end
endmodule : nvm_write_timer
`default_nettype wire

// ==== test/nvm_self_write_control_tb.sv ====
// self-checking bench for the self-write controller
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module nvm_self_write_control_tb;
  import nvm_ctl_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] stb = 10'h000;
  logic [7:0] wd = 8'h00;
  logic rs = 1'b0;
  logic llo = 1'b0;
  logic es = 1'b0;
  logic we = 1'b0;
  logic [1:0] wp = 2'h3;
  logic cp = 1'b0;
  logic [14:0] pa = 15'h0000;
  logic [14:0] fa = 15'h0000;
  logic [14:0] addr_o;
  logic [13:0] rd_o;
  logic [13:0] fd_o;
  logic [13:0] pd_o;
  logic busy;
  logic rbusy;
  logic err;
  logic pclr;
  int miscompares = 0;
  int checked = 0;
  logic [13:0] v;
  int n;

  always #20 clock_i = ~clock_i;

  nvm_self_write_control dut_u (
    .clock_i(clock_i), .reset_i(reset_i),
    .address_low_byte_we_i(stb[0]), .address_high_byte_we_i(stb[1]),
    .data_low_byte_we_i(stb[2]), .data_high_byte_we_i(stb[3]),
    .unlock_key_register_we_i(stb[4]), .write_data_i(wd),
    .region_select_i(rs), .latch_load_only_i(llo), .erase_select_i(es),
    .write_enable_gate_i(we), .write_start_set_i(stb[5]), .read_start_set_i(stb[6]),
    .write_error_clear_i(stb[7]), .write_protect_range_i(wp),
    .program_code_protect_i(cp), .data_code_protect_i(1'b0),
    .prog_read_i(stb[9]), .prog_bulk_erase_i(stb[8]), .prog_address_i(pa),
    .fetch_address_i(fa), .address_o(addr_o), .read_data_o(rd_o),
    .write_busy_o(busy), .read_busy_o(rbusy), .write_error_flag_o(err),
    .fetch_data_o(fd_o), .prog_data_o(pd_o), .protect_cleared_o(pclr)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task tick;
    @(posedge clock_i);
    #1;
  endtask : tick

  task check(input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // one strobe pulse, then one idle cycle
  task wr(input int k, input logic [7:0] d);
    wd = d;
    stb[k] = 1'b1;
    tick;
    stb[k] = 1'b0;
    tick;
  endtask : wr

  task go;
    wr(4, key_first);
    wr(4, key_second);
    wr(5, 8'h00);
  endtask : go

  task at(input logic [14:0] a);
    wr(0, a[7:0]);
    wr(1, {1'b0, a[14:8]});
  endtask : at

  task rd(input logic [14:0] a, output logic [13:0] d);
    at(a);
    wr(6, 8'h00);
    d = rd_o;
  endtask : rd

  task wait_done(output int cnt);
    cnt = 0;
    for (int i = 0; i < 5 && busy !== 1'b1; i++) tick;
    while (busy === 1'b1 && cnt < 300) begin
      tick;
      cnt++;
    end
    if (busy !== 1'b0 || cnt == 0) begin
      miscompares++;
      test_done;
    end
  endtask : wait_done

  function automatic logic [13:0] pat(input int i);
    return {6'(i + 40), 8'(i * 3 + 1)};
  endfunction : pat

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    test_done;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) tick;
    reset_i = 1'b0;
    cp = 1'b1;
    wr(8, 8'h00);
    repeat (60) tick;
    check(pclr, 14'h0001);
    rd(15'h0040, v);
    check(v, erased_word);
    check(rbusy, 14'h0000);
    // row write through the latches
    we = 1'b1;
    llo = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (i == 31) begin
        rd(15'h0040, v);
        check(v, erased_word);
        llo = 1'b0;
      end
      at(15'h0040 + 15'(i));
      v = pat(i);
      wr(2, v[7:0]);
      wr(3, {2'b00, v[13:8]});
      go;
      if (i < 31) check(busy, 14'h0000);
    end
    wait_done(n);
    check(14'(n >= int'(write_cycles) - 3 && n <= int'(write_cycles) + 2), 14'h0001);
    check(err, 14'h0000);
    check(busy, 14'h0000);
    for (int i = 0; i < 32; i++) begin
      rd(15'h0040 + 15'(i), v);
      check(v, pat(i));
    end
    // second program without erase only clears bits
    at(15'h0040);
    wr(2, 8'hF0);
    wr(3, 8'h1F);
    go;
    wait_done(n);
    rd(15'h0040, v);
    check(v, pat(0) & 14'h1FF0);
    // fetch and programmer paths
    fa = 15'h0041;
    tick;
    tick;
    check(fd_o, pat(1));
    pa = 15'h0041;
    wr(9, 8'h00);
    check(pd_o, 14'h0000);
    cp = 1'b0;
    wr(9, 8'h00);
    check(pd_o, pat(1));
    // row erase from a mid-row address
    es = 1'b1;
    at(15'h0047);
    go;
    wait_done(n);
    rd(15'h0040, v);
    check(v, erased_word);
    rd(15'h005F, v);
    check(v, erased_word);
    // protect ranges against an erase at 300h
    for (int p = 0; p < 4; p++) begin
      wp = 2'(p);
      wr(7, 8'h00);
      at(15'h0300);
      go;
      if (p < 2) begin
        check(err, 14'h0001);
        check(busy, 14'h0000);
      end else begin
        wait_done(n);
        check(err, 14'h0000);
      end
    end
    // eeprom write with region select set
    es = 1'b0;
    rs = 1'b1;
    at(15'h0010);
    wr(2, 8'h5A);
    go;
    wait_done(n);
    rd(15'h0010, v);
    check(v, 14'h005A);
    rs = 1'b0;
    rd(15'h0010, v);
    check(v, erased_word);
    // broken unlock and enable clear
    wr(7, 8'h00);
    at(15'h0040);
    wr(4, key_first);
    wr(2, 8'h00);
    wr(4, key_second);
    wr(5, 8'h00);
    check(err, 14'h0001);
    check(busy, 14'h0000);
    we = 1'b0;
    wr(7, 8'h00);
    go;
    check(busy, 14'h0000);
    check(err, 14'h0000);
    // reset in mid-write
    we = 1'b1;
    wr(7, 8'h00);
    go;
    tick;
    reset_i = 1'b1;
    tick;
    reset_i = 1'b0;
    tick;
    check(err, 14'h0001);
    check(busy, 14'h0000);
    test_done;
  end
endmodule : nvm_self_write_control_tb
`default_nettype wire
